//--- ppm_pkg.sv
// package: register map, field layout, reset values and link carriers of the pma link block
package ppm_pkg;
  // register byte offsets on the apb port
  localparam logic [11:0] OFF_TXDIS = 12'h000;
  localparam logic [11:0] OFF_EXTAB = 12'h004;
  localparam logic [11:0] OFF_ID_HI = 12'h008;
  localparam logic [11:0] OFF_ID_LO = 12'h00c;
  localparam logic [11:0] OFF_STAT = 12'h010;
  localparam logic [11:0] OFF_LCTRL = 12'h014;
  localparam logic [11:0] OFF_LSTAT = 12'h018;
  localparam logic [11:0] OFF_OPCTRL = 12'h01c;
  localparam logic [11:0] OFF_OPRES = 12'h020;
  localparam logic [11:0] OFF_ERRCNT = 12'h024;
  // link control field positions
  localparam int LC_START = 0;
  localparam int LC_HS_EN = 1;
  localparam int LC_CDOWN = 2;
  localparam int LC_IGN_HS = 3;
  localparam int LC_SUB_LSB = 4;
  localparam int LC_MODE_LSB = 8;
  // port subtypes and link-state codes
  localparam logic [1:0] SUB_OFFICE = 2'h0;
  localparam logic [1:0] SUB_REMOTE = 2'h1;
  localparam logic [3:0] SUB_SUPPORTED = 4'h3;
  localparam logic [3:0] MODE_SUPPORTED = 4'h3;
  localparam logic [2:0] LS_DOWN_QUIET = 3'h0;
  localparam logic [2:0] LS_INIT = 3'h1;
  localparam logic [2:0] LS_UP = 3'h2;
  localparam logic [2:0] LS_DOWN_TONES = 3'h4;
  // reset values
  localparam logic [1:0] RST_SUBTYPE = 2'h0;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [4:0] RST_TXDIS = 5'h00;
  // operation timeout
  localparam longint OP_TIMEOUT_S = 10;
  localparam longint CLK_HZ = 100000000;
  localparam longint OP_TIMEOUT_CYC = OP_TIMEOUT_S * CLK_HZ;
  localparam int TMR_W = 30;
  localparam int ERR_W = 16;

  typedef struct packed {
    logic link_up;
    logic link_init;
    logic tones_det;
    logic [3:0] linked_port;
    logic [1:0] op_done;
    logic [1:0] op_ok;
    logic err_evt;
  } ppm_link_in_t;

  typedef struct packed {
    logic [3:0] lane_tx_en;
    logic tx_en;
    logic link_start;
    logic hs_tone_en;
    logic hs_answer_en;
    logic cleardown_cmd;
    logic [1:0] subtype;
    logic [1:0] mode;
    logic [1:0] op_start;
    logic [1:0] op_abort;
  } ppm_link_out_t;
endpackage

//--- ppm_link_ctrl.sv
// apb register bank and link-control logic of the pma management unit
// Notes on behaviour
// - lane bits 3..1 disable lanes 2..0
// - lane bit 4 disables lane 3
// - global bit stops all; enable needs all zero
// - extended ability register ignores writes
// - identifier built from vendor, model, revision
// - link status shows down while initializing
// - latching-low status holds low until read
// - link start forced one while up/initializing
// - handshake enable reloads by subtype on down
// - no handshake tones while enable zero
// - subtype writes need support and link down
// - cleardown write issues cleardown command
// - device self-clears cleardown bit, also reset
// - cleardown accepted only in down-ready state
// - ignore bit suppresses answering handshake tones
// - unsupported mode-select writes are discarded
// - linked-port bits zero when not up
// - link-state code 001, 000, 100
// - get/send bits one while running
// - ten second timeout ends op, failed
// - start while down completes failed at once
// - result bits hold latest op outcome
// - result bits clear on read, reset
// - error counter clears on read, reset
// - error counter saturates at all ones
`timescale 1ns/100ps
`default_nettype none
module ppm_link_ctrl #(
  parameter longint OP_TIMEOUT_CYCLES = ppm_pkg::OP_TIMEOUT_CYC,
  parameter logic [21:0] VENDOR_ORG_IDENTIFIER = 22'h00abcd, // arbitrary value
  parameter logic [5:0] MODEL_NUM = 6'h05, // arbitrary value
  parameter logic [3:0] REV_NUM = 4'h1, // arbitrary value
  parameter logic [15:0] EXT_ABILITY = 16'h0001
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ppm_pkg::ppm_link_in_t link_in,
  output ppm_pkg::ppm_link_out_t link_out
);
  typedef struct packed {
    logic [4:0] txdis;
    logic link_start;
    logic hs_en;
    logic cdown;
    logic ign_hs;
    logic [1:0] subtype;
    logic [1:0] mode;
    logic stat_latch;
    logic prev_down;
    logic [1:0] busy;
    logic [1:0] res;
    logic [1:0][ppm_pkg::TMR_W-1:0] tmr;
    logic [ppm_pkg::ERR_W-1:0] errcnt;
    logic [1:0] start;
    logic [1:0] abort;
    logic [31:0] rdata;
    logic err;
  } ppm_state_t;

  localparam logic [ppm_pkg::TMR_W-1:0] TMR_LAST = ppm_pkg::TMR_W'(OP_TIMEOUT_CYCLES - 1);

  ppm_state_t state_reg;
  ppm_state_t state_next;
  logic down;
  logic [2:0] lstate;
  logic rd_setup;
  logic wr_acc;
  logic [31:0] rd_val;
  logic rd_hit;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  function automatic logic in_mask(input logic [3:0] m, input logic [1:0] v);
    in_mask = m[v];
  endfunction

  assign down = !link_in.link_up && !link_in.link_init;
  assign rd_setup = psel && !penable && !pwrite;
  // writes commit only at the access edge, as the master holds the request
  assign wr_acc = psel && penable && pwrite;

  always_comb begin
    if (link_in.link_init) begin
      lstate = ppm_pkg::LS_INIT;
    end else if (link_in.link_up) begin
      lstate = ppm_pkg::LS_UP;
    end else if (link_in.tones_det) begin
      lstate = ppm_pkg::LS_DOWN_TONES;
    end else begin
      lstate = ppm_pkg::LS_DOWN_QUIET;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (hit(paddr, ppm_pkg::OFF_TXDIS)) begin
      rd_val = {27'h0, state_reg.txdis};
    end else if (hit(paddr, ppm_pkg::OFF_EXTAB)) begin
      rd_val = {16'h0, EXT_ABILITY};
    end else if (hit(paddr, ppm_pkg::OFF_ID_HI)) begin
      rd_val = {16'h0, VENDOR_ORG_IDENTIFIER[21:6]};
    end else if (hit(paddr, ppm_pkg::OFF_ID_LO)) begin
      rd_val = {16'h0, VENDOR_ORG_IDENTIFIER[5:0], MODEL_NUM, REV_NUM};
    end else if (hit(paddr, ppm_pkg::OFF_STAT)) begin
      rd_val = {31'h0, state_reg.stat_latch};
    end else if (hit(paddr, ppm_pkg::OFF_LCTRL)) begin
      rd_val = {22'h0, state_reg.mode, 2'h0, state_reg.subtype, state_reg.ign_hs,
        state_reg.cdown, state_reg.hs_en, state_reg.link_start};
    end else if (hit(paddr, ppm_pkg::OFF_LSTAT)) begin
      // linked-port bits are meaningless until the link is up
      rd_val = {24'h0, link_in.link_up ? link_in.linked_port : 4'h0, 1'b0, lstate};
    end else if (hit(paddr, ppm_pkg::OFF_OPCTRL)) begin
      rd_val = {30'h0, state_reg.busy};
    end else if (hit(paddr, ppm_pkg::OFF_OPRES)) begin
      rd_val = {30'h0, state_reg.res};
    end else if (hit(paddr, ppm_pkg::OFF_ERRCNT)) begin
      rd_val = {16'h0, state_reg.errcnt};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.cdown = 1'b0;
    state_next.start = 2'h0;
    state_next.abort = 2'h0;
    // read data and clear-on-read side effects happen at the setup edge
    if (psel && !penable) begin
      state_next.err = !rd_hit;
      state_next.rdata = pwrite ? 32'h0000_0000 : rd_val;
    end
    // latching low: a low event sticks, a read reloads the current level
    if (rd_setup && hit(paddr, ppm_pkg::OFF_STAT)) begin
      state_next.stat_latch = link_in.link_up;
    end else if (!link_in.link_up) begin
      state_next.stat_latch = 1'b0;
    end
    if (rd_setup && hit(paddr, ppm_pkg::OFF_OPRES)) begin
      state_next.res = 2'h0;
    end
    if (rd_setup && hit(paddr, ppm_pkg::OFF_ERRCNT)) begin
      state_next.errcnt = '0;
    end
    if (link_in.err_evt) begin
      // an event in the clearing cycle counts as the first of the new run
      if (rd_setup && hit(paddr, ppm_pkg::OFF_ERRCNT)) begin
        state_next.errcnt = ppm_pkg::ERR_W'(1);
      end else if (state_reg.errcnt != '1) begin
        state_next.errcnt = state_reg.errcnt + ppm_pkg::ERR_W'(1);
      end
    end
    if (wr_acc && hit(paddr, ppm_pkg::OFF_TXDIS) && pstrb[0]) begin
      state_next.txdis = pwdata[4:0];
    end
    // extended ability and identifier have no storage, so writes fall away
    if (wr_acc && hit(paddr, ppm_pkg::OFF_LCTRL)) begin
      if (pstrb[0]) begin
        if (down) begin
          state_next.link_start = pwdata[ppm_pkg::LC_START];
        end
        state_next.hs_en = pwdata[ppm_pkg::LC_HS_EN];
        if (pwdata[ppm_pkg::LC_CDOWN] && lstate == ppm_pkg::LS_DOWN_QUIET) begin
          state_next.cdown = 1'b1;
        end
        state_next.ign_hs = pwdata[ppm_pkg::LC_IGN_HS];
        if (down && in_mask(ppm_pkg::SUB_SUPPORTED, pwdata[ppm_pkg::LC_SUB_LSB +: 2])) begin
          state_next.subtype = pwdata[ppm_pkg::LC_SUB_LSB +: 2];
        end
      end
      if (pstrb[1] && in_mask(ppm_pkg::MODE_SUPPORTED, pwdata[ppm_pkg::LC_MODE_LSB +: 2])) begin
        state_next.mode = pwdata[ppm_pkg::LC_MODE_LSB +: 2];
      end
    end
    if (!down) begin
      state_next.link_start = 1'b1;
    end
    state_next.prev_down = down;
    if (down && !state_reg.prev_down) begin
      state_next.hs_en = (state_next.subtype == ppm_pkg::SUB_REMOTE);
    end
    for (int i = 0; i < 2; i++) begin
      if (state_reg.busy[i]) begin
        state_next.tmr[i] = state_reg.tmr[i] + ppm_pkg::TMR_W'(1);
        if (link_in.op_done[i]) begin
          state_next.busy[i] = 1'b0;
          state_next.res[i] = link_in.op_ok[i];
        end else if (state_reg.tmr[i] == TMR_LAST) begin
          state_next.busy[i] = 1'b0;
          state_next.res[i] = 1'b0;
          state_next.abort[i] = 1'b1;
        end
      end else if (wr_acc && hit(paddr, ppm_pkg::OFF_OPCTRL) && pstrb[0] && pwdata[i]) begin
        if (!link_in.link_up) begin
          state_next.res[i] = 1'b0;
        end else begin
          state_next.busy[i] = 1'b1;
          state_next.tmr[i] = '0;
          state_next.start[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.txdis <= ppm_pkg::RST_TXDIS;
      state_reg.subtype <= ppm_pkg::RST_SUBTYPE;
      state_reg.mode <= ppm_pkg::RST_MODE;
      state_reg.hs_en <= (ppm_pkg::RST_SUBTYPE == ppm_pkg::SUB_REMOTE);
      state_reg.prev_down <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && state_reg.err;

  always_comb begin
    link_out.lane_tx_en = ~state_reg.txdis[4:1] & {4{!state_reg.txdis[0]}};
    link_out.tx_en = (state_reg.txdis == 5'h00);
    link_out.link_start = state_reg.link_start;
    link_out.hs_tone_en = state_reg.hs_en;
    link_out.hs_answer_en = !state_reg.ign_hs;
    link_out.cleardown_cmd = state_reg.cdown;
    link_out.subtype = state_reg.subtype;
    link_out.mode = state_reg.mode;
    link_out.op_start = state_reg.start;
    link_out.op_abort = state_reg.abort;
  end
endmodule
`default_nettype wire

//--- ppm_link_ctrl_chk.sv
// port-level assertions of the pma link register block
`timescale 1ns/100ps
`default_nettype none
module ppm_link_ctrl_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ppm_pkg::ppm_link_in_t link_in,
  input wire ppm_pkg::ppm_link_out_t link_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr = psel && penable && pwrite && pstrb[0];
  wire logic wtx = wr && paddr == ppm_pkg::OFF_TXDIS;
  wire logic act = link_in.link_up || link_in.link_init;
  wire logic quiet = !act && !link_in.tones_det;
  // the global bit gates every lane enable as well
  property p_lane;
    wtx |=> link_out.lane_tx_en == (~$past(pwdata[4:1]) & {4{!$past(pwdata[0])}});
  endproperty
  property p_glob; wtx |=> link_out.tx_en == ($past(pwdata[4:0]) == 5'h00); endproperty
  property p_start; act |=> link_out.link_start; endproperty
  property p_sub; act |=> $stable(link_out.subtype); endproperty
  property p_mode; ppm_pkg::MODE_SUPPORTED[link_out.mode]; endproperty
  property p_cd;
    link_out.cleardown_cmd |-> $past(wr && paddr == ppm_pkg::OFF_LCTRL && quiet && pwdata[2]);
  endproperty
  property p_ops;
    link_out.op_start[0] |-> $past(wr && paddr == ppm_pkg::OFF_OPCTRL && link_in.link_up && pwdata[0]);
  endproperty
  // only a fresh entry into down reloads the handshake enable
  property p_hs;
    act ##1 !act |=> link_out.hs_tone_en == (link_out.subtype == ppm_pkg::SUB_REMOTE);
  endproperty
  a_lane: assert property (p_lane) else $error("lane enable mismatch");
  a_glob: assert property (p_glob) else $error("global enable mismatch");
  a_start: assert property (p_start) else $error("link start dropped");
  a_sub: assert property (p_sub) else $error("subtype changed while active");
  a_mode: assert property (p_mode) else $error("unsupported mode held");
  a_cd: assert property (p_cd) else $error("cleardown without ready write");
  a_ops: assert property (p_ops) else $error("get started while down");
  a_hs: assert property (p_hs) else $error("handshake enable not reloaded");
  c_cd: cover property (link_out.cleardown_cmd);
  c_ab: cover property (link_out.op_abort[1]);
  c_op: cover property (link_out.op_start[0]);
endmodule
bind ppm_link_ctrl ppm_link_ctrl_chk i_ppm_link_ctrl_chk (.clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .link_in, .link_out);
`default_nettype wire

//--- ppm_link_partner.sv
// far-end link model: link levels, delayed operation answers, error events
`timescale 1ns/100ps
`default_nettype none
module ppm_link_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] lvl,
  input wire logic ok,
  input wire logic err_on,
  input wire logic [7:0] lat,
  input wire ppm_pkg::ppm_link_out_t link_out,
  output ppm_pkg::ppm_link_in_t link_in
);
  logic [7:0] cnt;
  logic [1:0] pend;
  // port type shows even when not up, so masking is left to the block
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      pend <= 2'h0;
      link_in <= '0;
    end else begin
      link_in <= '0;
      {link_in.tones_det, link_in.link_init, link_in.link_up} <= lvl;
      link_in.linked_port <= 4'ha;
      link_in.err_evt <= err_on;
      if (link_out.op_start != 2'h0) begin
        pend <= link_out.op_start;
        cnt <= lat;
      end else if (cnt != 8'h00) cnt <= cnt - 8'h01;
      else if (lat != 8'hff && pend != 2'h0) begin
        link_in.op_done <= pend;
        link_in.op_ok <= {2{ok}};
        pend <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

//--- ppm_link_ctrl_test.sv
// self-checking bench of the pma link register block
`timescale 1ns/100ps
`default_nettype none
module ppm_link_ctrl_test;
  localparam logic [21:0] VOI = 22'h012345; // arbitrary value
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ok = 1, err_on = 0, erq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [2:0] lvl = 3'h0;
  logic [7:0] lat = 8'h05;
  logic pready, pslverr;
  ppm_pkg::ppm_link_in_t link_in;
  ppm_pkg::ppm_link_out_t link_out;
  int error_cnt = 0, check_count = 0, cd_cnt = 0;
  always #5 clk = ~clk;
  always @(negedge clk) cd_cnt += int'(link_out.cleardown_cmd === 1'b1);
  ppm_link_ctrl #(.OP_TIMEOUT_CYCLES(50), .VENDOR_ORG_IDENTIFIER(VOI)) i_ppm_link_ctrl (.clk,
    .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
    .link_in, .link_out);
  ppm_link_partner i_ppm_link_partner (.clk, .rst, .lvl, .ok, .err_on, .lat, .link_out, .link_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    erq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic lnk(input logic [2:0] v);
    @(posedge clk);
    lvl <= v;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_tx;
    logic [4:0] v[6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
    foreach (v[i]) begin
      xfer(1'b1, ppm_pkg::OFF_TXDIS, 32'(v[i]));
      chk(32'(link_out.lane_tx_en), {28'h0, ~v[i][4:1] & {4{~v[i][0]}}});
      chk(32'(link_out.tx_en), 32'(v[i] == 5'h00));
    end
  endtask
  task automatic t_id;
    xfer(1'b1, ppm_pkg::OFF_EXTAB, 32'hffff);
    rdc(ppm_pkg::OFF_EXTAB, 32'h1);
    rdc(ppm_pkg::OFF_ID_HI, 32'(VOI[21:6]));
    rdc(ppm_pkg::OFF_ID_LO, 32'({VOI[5:0], 6'h05, 4'h1}));
    rdc(12'h0fc, 32'h0);
    chk(32'(erq), 32'h1);
  endtask
  task automatic t_link;
    lnk(3'h2);
    rdc(ppm_pkg::OFF_LSTAT, 32'h1);
    rdc(ppm_pkg::OFF_STAT, 32'h0);
    xfer(1'b1, ppm_pkg::OFF_LCTRL, 32'h0);
    chk(32'(link_out.link_start), 32'h1);
    lnk(3'h4);
    rdc(ppm_pkg::OFF_LSTAT, 32'h4);
    lnk(3'h1);
    rdc(ppm_pkg::OFF_LSTAT, 32'ha2);
    lnk(3'h0);
    rdc(ppm_pkg::OFF_LSTAT, 32'h0);
    lnk(3'h1);
    rdc(ppm_pkg::OFF_STAT, 32'h0);
    rdc(ppm_pkg::OFF_STAT, 32'h1);
  endtask
  task automatic t_ctl;
    lnk(3'h4);
    xfer(1'b1, ppm_pkg::OFF_LCTRL, 32'h4);
    lnk(3'h0);
    xfer(1'b1, ppm_pkg::OFF_LCTRL, 32'h214);
    chk(32'({link_out.subtype, link_out.mode}), 32'h4);
    rdc(ppm_pkg::OFF_LCTRL, 32'h10);
    chk(32'(cd_cnt), 32'h1);
    xfer(1'b1, ppm_pkg::OFF_LCTRL, 32'h128);
    chk(32'({link_out.subtype, link_out.mode, link_out.hs_answer_en}), 32'ha);
    lnk(3'h1);
    xfer(1'b1, ppm_pkg::OFF_LCTRL, 32'h0);
    chk(32'({link_out.subtype, link_out.hs_tone_en, link_out.hs_answer_en}), 32'h5);
    lnk(3'h0);
    chk(32'(link_out.hs_tone_en), 32'h1);
  endtask
  task automatic t_op;
    lnk(3'h1);
    xfer(1'b1, ppm_pkg::OFF_OPCTRL, 32'h3);
    rdc(ppm_pkg::OFF_OPCTRL, 32'h3);
    repeat (12) @(posedge clk);
    rdc(ppm_pkg::OFF_OPCTRL, 32'h0);
    lnk(3'h0);
    xfer(1'b1, ppm_pkg::OFF_OPCTRL, 32'h1);
    rdc(ppm_pkg::OFF_OPCTRL, 32'h0);
    rdc(ppm_pkg::OFF_OPRES, 32'h2);
    rdc(ppm_pkg::OFF_OPRES, 32'h0);
    lnk(3'h1);
    // a good send first, so the timeout has a result to overturn and a timer to restart
    xfer(1'b1, ppm_pkg::OFF_OPCTRL, 32'h2);
    repeat (12) @(posedge clk);
    lat <= 8'hff;
    xfer(1'b1, ppm_pkg::OFF_OPCTRL, 32'h2);
    repeat (44) @(posedge clk);
    rdc(ppm_pkg::OFF_OPCTRL, 32'h2);
    repeat (10) @(posedge clk);
    rdc(ppm_pkg::OFF_OPCTRL, 32'h0);
    rdc(ppm_pkg::OFF_OPRES, 32'h0);
  endtask
  // more events than the counter holds, to reach saturation
  task automatic t_err;
    @(posedge clk);
    err_on <= 1'b1;
    repeat (65540) @(posedge clk);
    err_on <= 1'b0;
    rdc(ppm_pkg::OFF_ERRCNT, 32'hffff);
    rdc(ppm_pkg::OFF_ERRCNT, 32'h0);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_tx();
    t_id();
    t_link();
    t_ctl();
    t_op();
    t_err();
    print_verdict();
  end
  initial begin
    #800us;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
